// ### rtl/pps_pkg.sv
/*
 * Constants and carrier types of the protection policy register block.
 * Assumes an 8-bit internal register port driven by a serial bus front end.
 */
package pps_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] PPS_ADDR_STATUS1 = 8'h00;
    localparam logic [7:0] PPS_ADDR_LEVEL   = 8'h02;
    localparam logic [7:0] PPS_ADDR_POLICY  = 8'h05;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         PPS_STAT_OVL_BIT = 0;
    localparam int         PPS_STAT_OHT_BIT = 6;
    localparam int         PPS_SYNC_STAGES  = 2;
    localparam logic [7:0] PPS_POLICY_RST   = 8'h00;
    localparam logic [7:0] PPS_LEVEL_RST    = 8'h00;
    localparam logic [7:0] PPS_RDATA_RST    = 8'h00;
    localparam logic [3:0] PPS_LEVEL_OFF    = 4'h0;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       comp_low_esr;
        logic       overheat_restart_policy;
        logic [1:0] rsvd_5_4;
        logic       overload_restart_policy;
        logic [2:0] rsvd_2_0;
    } pps_policy_t;

    typedef struct packed {
        logic [3:0] rsvd_7_4;
        logic [3:0] output_level_select;
    } pps_level_t;

    typedef struct packed {
        logic       overload_flag;
        logic       overtemperature_flag;
    } pps_flags_t;

endpackage : pps_pkg

// ### rtl/pps_sync.sv
/*
 * Two-stage synchroniser for a group of level inputs.
 * Assumes inputs are levels that stay put far longer than one clock.
 */
`timescale 1ns/1ns
module pps_sync
    import pps_pkg::*;
#(
    parameter int WIDTH = 2
)
(
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // ------------------------------------------------------------
    // Stage logic
    // ------------------------------------------------------------
    // First stage feeds only the second stage
    always_comb
    begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule : pps_sync

// ### rtl/pps_top.sv
/*
 * Protection policy register and output recovery control of a dish
 * supply controller, with the level select and status registers it acts on.
 * Assumes a serial front end presents single-cycle read and write strobes
 * with an 8-bit address, and that trip inputs come from analog comparators.
 */
// Overview of operation
// - Latched overload policy clears the level select and disables output.
// - Auto overload policy restores output with the old level on recovery.
// - Latched overheat policy clears the level select and disables output.
// - Auto overheat policy restores output with the old level on recovery.
// - The capacitor type bit picks low-ESR compensation at 1, standard at 0.
// - Every policy bit is zero after power-on reset.
// - The policy register sits at address 5 and reads back the last write.
// - Status bit 0 reads 1 while overload protection is active.
// - Status bit 6 reads 1 while overtemperature is detected.
`timescale 1ns/1ns
module pps_top
    import pps_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       overload_trip,
    input  wire logic       overheat_trip,
    output logic            supply_enable,
    output logic      [3:0] output_level_select,
    output logic            comp_low_esr
);

    pps_policy_t policy_q;
    pps_policy_t policy_d;
    pps_level_t  level_q;
    pps_level_t  level_d;
    pps_flags_t  flags;
    logic [1:0]  trips_sync;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;
    logic [7:0]  status_byte;
    logic        supply_q;
    logic        supply_d;
    logic        comp_q;
    logic        comp_d;
    logic        latch_clear;

    // ------------------------------------------------------------
    // Trip input synchronisation
    // ------------------------------------------------------------
    pps_sync #(
        .WIDTH    (2)
    ) pps_sync_inst (
        .clock    (clock),
        .rst_b    (rst_b),
        .async_in ({overload_trip, overheat_trip}),
        .sync_out (trips_sync)
    );

    always_comb
    begin
        flags.overload_flag        = trips_sync[1];
        flags.overtemperature_flag = trips_sync[0];
        status_byte                = 8'h00;
        status_byte[PPS_STAT_OVL_BIT] = flags.overload_flag;
        status_byte[PPS_STAT_OHT_BIT] = flags.overtemperature_flag;
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // A latched trip keeps clearing the level while it lasts, so a host
    // write made during the fault cannot re-arm the output early
    always_comb
    begin
        latch_clear = (flags.overload_flag
                       && policy_q.overload_restart_policy)
                      || (flags.overtemperature_flag
                       && policy_q.overheat_restart_policy);
        policy_d = policy_q;
        level_d  = level_q;
        if (reg_wr && reg_addr == PPS_ADDR_POLICY)
        begin
            policy_d = pps_policy_t'(reg_wdata);
        end
        if (reg_wr && reg_addr == PPS_ADDR_LEVEL)
        begin
            level_d = pps_level_t'(reg_wdata);
        end
        if (latch_clear)
        begin
            level_d.output_level_select = PPS_LEVEL_OFF;
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            policy_q <= pps_policy_t'(PPS_POLICY_RST);
            level_q  <= pps_level_t'(PPS_LEVEL_RST);
        end
        else
        begin
            policy_q <= policy_d;
            level_q  <= level_d;
        end
    end

    // ------------------------------------------------------------
    // Output control
    // ------------------------------------------------------------
    // Auto policy simply holds the output off while a flag is up; the
    // stored level survives, so recovery restores the old setting
    always_comb
    begin
        supply_d = (level_d.output_level_select != PPS_LEVEL_OFF)
                   && !flags.overload_flag
                   && !flags.overtemperature_flag;
        comp_d   = policy_d.comp_low_esr;
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            supply_q <= 1'h0;
            comp_q   <= 1'h0;
        end
        else
        begin
            supply_q <= supply_d;
            comp_q   <= comp_d;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Unmapped and write-only addresses read as zero
    always_comb
    begin
        rdata_d = rdata_q;
        if (reg_rd)
        begin
            case (reg_addr)
                PPS_ADDR_STATUS1: rdata_d = status_byte;
                PPS_ADDR_LEVEL:   rdata_d = level_q;
                PPS_ADDR_POLICY:  rdata_d = policy_q;
                default:          rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata_q <= PPS_RDATA_RST;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata           = rdata_q;
    assign supply_enable       = supply_q;
    assign output_level_select = level_q.output_level_select;
    assign comp_low_esr        = comp_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic wr_level;
    assign wr_level = reg_wr && reg_addr == PPS_ADDR_LEVEL;

    a_ovl_latch_clear: assert property (
        @(posedge clock) disable iff (!rst_b)
        flags.overload_flag && policy_q.overload_restart_policy
        |=> output_level_select == 4'h0 && !supply_enable)
        else $error("latched overload did not clear level");

    a_ovl_auto_keep: assert property (
        @(posedge clock) disable iff (!rst_b)
        flags.overload_flag && !policy_q.overload_restart_policy
        && !flags.overtemperature_flag && !wr_level
        |=> $stable(output_level_select) && !supply_enable)
        else $error("auto overload lost the level setting");

    a_ovl_auto_restore: assert property (
        @(posedge clock) disable iff (!rst_b)
        $fell(flags.overload_flag) && !flags.overtemperature_flag
        && !wr_level && !latch_clear
        |=> supply_enable == (output_level_select != 4'h0))
        else $error("auto overload did not restore output");

    a_oht_latch_clear: assert property (
        @(posedge clock) disable iff (!rst_b)
        flags.overtemperature_flag && policy_q.overheat_restart_policy
        |=> output_level_select == 4'h0 && !supply_enable)
        else $error("latched overheat did not clear level");

    a_oht_auto_keep: assert property (
        @(posedge clock) disable iff (!rst_b)
        flags.overtemperature_flag && !policy_q.overheat_restart_policy
        && !flags.overload_flag && !wr_level
        |=> $stable(output_level_select) && !supply_enable)
        else $error("auto overheat lost the level setting");

    a_oht_auto_restore: assert property (
        @(posedge clock) disable iff (!rst_b)
        $fell(flags.overtemperature_flag) && !flags.overload_flag
        && !wr_level && !latch_clear
        |=> supply_enable == (output_level_select != 4'h0))
        else $error("auto overheat did not restore output");

    a_comp_follow: assert property (
        @(posedge clock) disable iff (!rst_b)
        reg_wr && reg_addr == PPS_ADDR_POLICY
        |=> comp_low_esr == $past(reg_wdata[7]))
        else $error("compensation select did not follow write");

    a_reset_zero: assert property (
        @(posedge clock)
        $rose(rst_b) |-> policy_q == 8'h00 && comp_low_esr == 1'h0)
        else $error("policy not zero after reset");

    a_policy_readback: assert property (
        @(posedge clock) disable iff (!rst_b)
        reg_wr && reg_addr == PPS_ADDR_POLICY
        ##1 reg_rd && reg_addr == PPS_ADDR_POLICY && !reg_wr
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("policy read did not return last write");

    a_status_flags: assert property (
        @(posedge clock) disable iff (!rst_b)
        reg_rd && reg_addr == PPS_ADDR_STATUS1
        |=> reg_rdata[0] == $past(flags.overload_flag)
            && reg_rdata[6] == $past(flags.overtemperature_flag))
        else $error("status flags read wrong");

    c_ovl_latched: cover property (
        @(posedge clock) disable iff (!rst_b)
        flags.overload_flag && policy_q.overload_restart_policy
        && output_level_select != 4'h0);

    c_ovl_auto: cover property (
        @(posedge clock) disable iff (!rst_b)
        $fell(flags.overload_flag) && !policy_q.overload_restart_policy
        ##1 supply_enable);

    c_oht_latched: cover property (
        @(posedge clock) disable iff (!rst_b)
        flags.overtemperature_flag && policy_q.overheat_restart_policy
        ##1 output_level_select == 4'h0);

    c_policy_read: cover property (
        @(posedge clock) disable iff (!rst_b)
        reg_rd && reg_addr == PPS_ADDR_POLICY && policy_q != 8'h00);

endmodule : pps_top

// ### test/pps_host.sv
/*
 * Host model: single-byte register writes and reads on the strobe port.
 * Assumes the port of pps_top, sampled on the rising clock edge.
 */
`timescale 1ns/1ns
module pps_host
    import pps_pkg::*;
(
    input  wire logic       clock,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    initial
    begin
        reg_addr  = 8'h5a;
        reg_wdata = 8'ha5;
        reg_wr    = 1'h0;
        reg_rd    = 1'h0;
    end

    // Idle lines show the inverse so a stale value never passes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= (a == PPS_ADDR_POLICY) ? (d & 8'hc8) : d;
        reg_wr    <= 1'h1;
        @(posedge clock);
        reg_wr    <= 1'h0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge clock);
        reg_rd   <= 1'h0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask : rd

    // Write then read the same address on the very next edge
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] q);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= (a == PPS_ADDR_POLICY) ? (d & 8'hc8) : d;
        reg_wr    <= 1'h1;
        @(posedge clock);
        reg_wr    <= 1'h0;
        reg_rd    <= 1'h1;
        reg_wdata <= ~d;
        @(posedge clock);
        reg_rd    <= 1'h0;
        reg_addr  <= ~a;
        #1;
        q = reg_rdata;
    endtask : wr_rd

    // Rewrite the level once both flags read clear, or after 20 status reads
    task automatic restore(input logic [7:0] lvl);
        logic [7:0] s;
        s = 8'hff;
        for (int i = 0; i < 20 && s !== 8'h00; i++)
            rd(PPS_ADDR_STATUS1, s);
        wr(PPS_ADDR_LEVEL, lvl);
    endtask : restore

endmodule : pps_host

// ### test/protection_policy_register_tb_top.sv
/*
 * Self-checking bench of the protection policy register block.
 * Assumes pps_top and the pps_host model; trip pins driven here.
 */
`timescale 1ns/1ns
`define CHK(n, e, g) check_val(n, 8'(e), 8'(g))
module protection_policy_register_tb_top
    import pps_pkg::*;
;
    logic       clock;
    logic       rst_b;
    logic [7:0] reg_addr;
    logic       reg_wr;
    logic [7:0] reg_wdata;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       overload_trip;
    logic       overheat_trip;
    logic       supply_enable;
    logic [3:0] output_level_select;
    logic       comp_low_esr;
    logic [7:0] d;
    int         n_errors;
    int         samples_checked;

    pps_top pps_top_inst (.clock(clock), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .overload_trip(overload_trip), .overheat_trip(overheat_trip),
        .supply_enable(supply_enable),
        .output_level_select(output_level_select),
        .comp_low_esr(comp_low_esr));

    pps_host pps_host_inst (.clock(clock), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check_val(input string n, input logic [7:0] e,
                             input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            n_errors++;
        end
    endtask : check_val

    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    // Trip pins are slow levels; six cycles cover the sync path
    task automatic trip(input logic ovl, input logic on);
        @(posedge clock);
        if (ovl)
            overload_trip <= on;
        else
            overheat_trip <= on;
        repeat (6) @(posedge clock);
        #1;
    endtask : trip

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        pps_host_inst.rd(PPS_ADDR_POLICY, d);
        `CHK("policy", 8'h00, d);
        `CHK("comp", 8'h00, comp_low_esr);
        `CHK("supply", 8'h00, supply_enable);
    endtask : t_reset

    task automatic t_policy();
        pps_host_inst.wr(PPS_ADDR_POLICY, 8'h80);
        `CHK("comp", 8'h01, comp_low_esr);
        pps_host_inst.rd(PPS_ADDR_POLICY, d);
        `CHK("policy", 8'h80, d);
        pps_host_inst.wr_rd(PPS_ADDR_POLICY, 8'h48, d);
        `CHK("policy", 8'h48, d);
        `CHK("comp", 8'h00, comp_low_esr);
        pps_host_inst.wr(PPS_ADDR_POLICY, 8'h00);
        `CHK("comp", 8'h00, comp_low_esr);
        pps_host_inst.rd(8'h07, d);
        `CHK("unmapped", 8'h00, d);
    endtask : t_policy

    task automatic t_auto(input logic ovl, input logic [7:0] st);
        pps_host_inst.wr(PPS_ADDR_POLICY, 8'h00);
        pps_host_inst.wr(PPS_ADDR_LEVEL, 8'h09);
        `CHK("supply", 8'h01, supply_enable);
        trip(ovl, 1'h1);
        pps_host_inst.rd(PPS_ADDR_STATUS1, d);
        `CHK("status", st, d);
        `CHK("supply", 8'h00, supply_enable);
        trip(ovl, 1'h0);
        `CHK("supply", 8'h01, supply_enable);
        `CHK("level", 8'h09, output_level_select);
        pps_host_inst.rd(PPS_ADDR_STATUS1, d);
        `CHK("status", 8'h00, d);
    endtask : t_auto

    task automatic t_latch(input logic ovl, input logic [7:0] pol);
        pps_host_inst.wr(PPS_ADDR_POLICY, pol);
        pps_host_inst.wr(PPS_ADDR_LEVEL, 8'h03);
        trip(ovl, 1'h1);
        `CHK("level", 8'h00, output_level_select);
        `CHK("supply", 8'h00, supply_enable);
        pps_host_inst.wr(PPS_ADDR_LEVEL, 8'h03);
        `CHK("level", 8'h00, output_level_select);
        `CHK("supply", 8'h00, supply_enable);
        trip(ovl, 1'h0);
        `CHK("supply", 8'h00, supply_enable);
        pps_host_inst.restore(8'h03);
        `CHK("level", 8'h03, output_level_select);
        `CHK("supply", 8'h01, supply_enable);
    endtask : t_latch

    // A reset in mid-run must drop a written policy back to zero
    task automatic t_mid_reset();
        pps_host_inst.wr(PPS_ADDR_POLICY, 8'hc8);
        pps_host_inst.wr(PPS_ADDR_LEVEL, 8'h05);
        `CHK("comp", 8'h01, comp_low_esr);
        @(posedge clock);
        rst_b <= 1'h0;
        repeat (3) @(posedge clock);
        rst_b <= 1'h1;
        pps_host_inst.rd(PPS_ADDR_POLICY, d);
        `CHK("policy", 8'h00, d);
        `CHK("comp", 8'h00, comp_low_esr);
        `CHK("supply", 8'h00, supply_enable);
    endtask : t_mid_reset

    // ------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        clock = 1'h0;
        forever #20 clock = ~clock;
    end

    initial
    begin
        rst_b           = 1'h0;
        overload_trip   = 1'h0;
        overheat_trip   = 1'h0;
        n_errors        = 0;
        samples_checked = 0;
        repeat (8) @(posedge clock);
        rst_b <= 1'h1;
        t_reset();
        t_policy();
        t_mid_reset();
        t_auto(1'h1, 8'h01);
        t_auto(1'h0, 8'h40);
        t_latch(1'h1, 8'h08);
        t_latch(1'h0, 8'h40);
        finish_test();
    end

    // Whole run needs about 125 cycles
    initial
    begin
        repeat (5000) @(posedge clock);
        n_errors++;
        finish_test();
    end

endmodule : protection_policy_register_tb_top
